// ===== inc/hce_defs.vh
// Constants for the hopping code frame encoder
`ifndef HCE_DEFS_VH
`define HCE_DEFS_VH
`define HCE_SYS_CLK_HZ 200000000
`define HCE_BIT_RATE_HZ 1000
`define HCE_BIT_RATE_MIN_HZ 500
`define HCE_BIT_RATE_MAX_HZ 5000
`define HCE_MAX_FRAMES 360
`define HCE_PRECODE_BITS 48
`define HCE_CODE_BITS 40
`define HCE_FUNC_BITS 4
`define HCE_SYM_BITS 3
`define HCE_BLANK_BITS 150
`define HCE_FRAME_BITS 343
`define HCE_DATA_BITS 193
`define HCE_SECURE_END 168
`define HCE_FUNC1_END 180
`define HCE_FUNC2_END 192
`define HCE_DEBOUNCE_CYCLES 168
`define HCE_FIFO_DEPTH 8
`define HCE_SEED 40'h5A3C96E1B7
`endif

// ===== rtl/hce_bit_fifo.v
// Small FIFO between the frame builder and the data pin stage
`timescale 1ns/1ps
`default_nettype none
module hce_bit_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sysClk, // System clock
  input wire rstn, // Asynchronous reset, active low
  input wire flush, // Discard all contents
  input wire inValid, // Write request
  output wire inReady, // Space available
  input wire [WIDTH-1:0] inData, // Write data
  output wire outValid, // Data available
  input wire outReady, // Read request
  output reg [WIDTH-1:0] outData // Read data, registered
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] count;
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg haveOut;
  wire doWrite;
  wire doRead;
  wire loadOut;
  assign inReady = (count != DEPTH[AW:0]);
  assign doWrite = inValid && inReady;
  assign outValid = haveOut;
  assign loadOut = (count != {(AW+1){1'b0}}) && (!haveOut || outReady);
  assign doRead = loadOut;

  function [AW-1:0] bump;
    input [AW-1:0] p;
    begin
      bump = (p == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : p + 1'b1;
    end
  endfunction

  always @(posedge sysClk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      count <= {(AW+1){1'b0}};
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      haveOut <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else if (flush) begin
      count <= {(AW+1){1'b0}};
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      haveOut <= 1'b0;
      outData <= {WIDTH{1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= bump(wrPtr);
      end
      if (doRead) begin
        rdPtr <= bump(rdPtr);
        outData <= mem[rdPtr];
        haveOut <= 1'b1;
      end else if (outReady) begin
        haveOut <= 1'b0;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (!doWrite && doRead) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hce_bit_divider.v
// Divider that makes the data clock tick enable
`timescale 1ns/1ps
`default_nettype none
module hce_bit_divider #(
  parameter DIV = 200000
) (
  input wire sysClk, // System clock
  input wire rstn, // Asynchronous reset, active low
  input wire restart, // Restart phase
  output reg tick // One-cycle data clock rising edge
);
  reg [31:0] cnt;
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (restart) begin
      cnt <= 32'h00000000;
      tick <= 1'b0;
    end else if (cnt == DIV - 1) begin
      cnt <= 32'h00000000;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 32'h00000001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== rtl/hce_frame_encoder.v
// Encoder-mode transmit framer for the hopping code remote control
`include "hce_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module hce_frame_encoder #(
  parameter BIT_DIV = `HCE_SYS_CLK_HZ / `HCE_BIT_RATE_HZ,
  parameter MAX_FRAMES = `HCE_MAX_FRAMES
) (
  input wire sysClk, // 200 MHz system clock
  input wire rstn, // Asynchronous reset, active low
  input wire modeSelectPin, // High or open selects encoder mode
  input wire [3:0] functionInputs, // Buttons, active low
  input wire learnedFlag, // A code was learned in decoder mode
  output reg serialData, // Serial data pin level
  output reg serialDataEnN, // Pin output enable, low while driving
  output reg bursting, // Burst in progress
  output reg standby, // Low-power standby
  output reg [39:0] securityCode, // Stored security code
  output reg codeStore // Pulse: store new code
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_SEND = 4'b0010;
  localparam ST_HOLD = 4'b0100;
  localparam ST_BOOT = 4'b1000;

  reg [3:0] state;
  reg [3:0] btnMeta;
  reg [3:0] btnSync;
  reg modeMeta;
  reg modeSync;
  reg encoderMode;
  reg modeCaught;
  reg [8:0] bitPos;
  reg [8:0] frameCount;
  reg [3:0] firstButtonSample;
  reg [3:0] secondButtonSample;
  reg divRestart;
  reg fifoFlush;
  reg [1:0] bootWait;
  wire tick;
  wire anyPressed;
  wire nextBit;
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoOutData;
  reg fifoPush;
  reg fifoBit;

  assign anyPressed = (btnSync != 4'hF);

  // Advance a 40-bit code one hopping step
  function [39:0] hop;
    input [39:0] c;
    begin
      hop = {c[38:0], c[39] ^ c[37] ^ c[20] ^ c[18]} + 40'h0000000001;
    end
  endfunction

  // Symbol bit at position p within a 3-bit symbol for data bit d
  function symBit;
    input [1:0] p;
    input d;
    begin
      symBit = (p == 2'h0) ? 1'b1 : ((p == 2'h1) ? d : 1'b0);
    end
  endfunction

  // Symbol level at offset o into a field whose data bits are w
  function fieldBit;
    input [8:0] o;
    input [39:0] w;
    reg [8:0] q;
    reg [8:0] r;
    begin
      q = o / 9'h003;
      r = o - q * 9'h003;
      fieldBit = symBit(r[1:0], w[q[5:0]]);
    end
  endfunction

  // Level of the frame at bit position p
  function frameBit;
    input [8:0] p;
    input [39:0] code;
    input [3:0] f1;
    input [3:0] f2;
    begin
      if (p < `HCE_PRECODE_BITS) begin
        frameBit = ~p[0];
      end else if (p < `HCE_SECURE_END) begin
        frameBit = fieldBit(p - 9'h030, code);
      end else if (p < `HCE_FUNC1_END) begin
        frameBit = fieldBit(p - 9'h0A8, {36'h000000000, f1});
      end else if (p < `HCE_FUNC2_END) begin
        frameBit = fieldBit(p - 9'h0B4, {36'h000000000, f2});
      end else if (p == `HCE_FUNC2_END) begin
        frameBit = 1'b1;
      end else begin
        frameBit = 1'b0;
      end
    end
  endfunction

  assign nextBit = frameBit(bitPos, securityCode, firstButtonSample,
    secondButtonSample);

  hce_bit_divider #(
    .DIV(BIT_DIV)
  ) uDiv (
    .sysClk(sysClk),
    .rstn(rstn),
    .restart(divRestart),
    .tick(tick)
  );

  hce_bit_fifo #(
    .WIDTH(1),
    .DEPTH(`HCE_FIFO_DEPTH),
    .AW(3)
  ) uFifo (
    .sysClk(sysClk),
    .rstn(rstn),
    .flush(fifoFlush),
    .inValid(fifoPush),
    .inReady(fifoInReady),
    .inData(fifoBit),
    .outValid(fifoOutValid),
    .outReady(tick),
    .outData(fifoOutData)
  );

  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      btnMeta <= 4'hF;
      btnSync <= 4'hF;
      modeMeta <= 1'b1;
      modeSync <= 1'b1;
    end else begin
      btnMeta <= functionInputs;
      btnSync <= btnMeta;
      modeMeta <= modeSelectPin;
      modeSync <= modeMeta;
    end
  end

  // Frame builder: one bit pushed per free FIFO slot
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_BOOT;
      encoderMode <= 1'b0;
      modeCaught <= 1'b0;
      bootWait <= 2'h0;
      bitPos <= 9'h000;
      frameCount <= 9'h000;
      firstButtonSample <= 4'hF;
      secondButtonSample <= 4'hF;
      securityCode <= `HCE_SEED;
      codeStore <= 1'b0;
      fifoPush <= 1'b0;
      fifoBit <= 1'b0;
      fifoFlush <= 1'b1;
      divRestart <= 1'b1;
      bursting <= 1'b0;
      standby <= 1'b0;
    end else begin
      codeStore <= 1'b0;
      fifoPush <= 1'b0;
      fifoFlush <= 1'b0;
      divRestart <= 1'b0;
      case (state)
        ST_BOOT: begin
          if (bootWait != 2'h2) begin
            bootWait <= bootWait + 2'h1; // Let the mode synchroniser fill
          end else if (!modeCaught) begin
            encoderMode <= modeSync;
            modeCaught <= 1'b1;
          end else begin
            if (learnedFlag) begin
              securityCode <= hop(securityCode ^ `HCE_SEED);
              codeStore <= 1'b1;
            end
            state <= ST_IDLE;
            standby <= 1'b1;
          end
        end
        ST_IDLE: begin
          frameCount <= 9'h000;
          if (encoderMode && anyPressed) begin
            state <= ST_SEND;
            bitPos <= 9'h000;
            firstButtonSample <= btnSync;
            standby <= 1'b0;
            bursting <= 1'b1;
            divRestart <= 1'b1;
          end
        end
        ST_SEND: begin
          if (!anyPressed) begin
            fifoFlush <= 1'b1;
            frameCount <= 9'h000;
            bursting <= 1'b0;
            standby <= 1'b1;
            securityCode <= hop(securityCode);
            codeStore <= 1'b1;
            state <= ST_IDLE;
          end else if (fifoInReady && !fifoPush) begin
            fifoPush <= 1'b1;
            fifoBit <= nextBit;
            if (bitPos == `HCE_SECURE_END - 1) begin
              secondButtonSample <= btnSync;
            end
            if (bitPos == `HCE_FRAME_BITS - 1) begin
              bitPos <= 9'h000;
              if (frameCount == MAX_FRAMES - 1) begin
                frameCount <= frameCount + 9'h001;
                state <= ST_HOLD;
              end else begin
                frameCount <= frameCount + 9'h001;
                firstButtonSample <= btnSync;
              end
            end else begin
              bitPos <= bitPos + 9'h001;
            end
          end
        end
        ST_HOLD: begin
          if (!fifoOutValid && bursting) begin
            bursting <= 1'b0;
            securityCode <= hop(securityCode);
            codeStore <= 1'b1;
          end
          if (!anyPressed) begin
            fifoFlush <= 1'b1;
            bursting <= 1'b0;
            frameCount <= 9'h000;
            standby <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin stage: level moves on data clock ticks and is cleared at once by a FIFO flush
  always @(posedge sysClk or negedge rstn) begin
    if (!rstn) begin
      serialData <= 1'b0;
      serialDataEnN <= 1'b1;
    end else begin
      serialDataEnN <= ~encoderMode;
      if (fifoFlush) begin
        serialData <= 1'b0;
      end else if (tick) begin
        serialData <= fifoOutValid ? fifoOutData : 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/hce_enc_chk.sv
// Port checker for the frame encoder
`timescale 1ns/1ps
`default_nettype none
module hce_enc_chk #(parameter BIT_DIV = 2) (
  input wire logic sysClk, // clock
  input wire logic rstn, // reset
  input wire logic modeSelectPin, // mode
  input wire logic [3:0] functionInputs, // keys
  input wire logic learnedFlag, // learned
  input wire logic serialData, // pin
  input wire logic serialDataEnN, // enable
  input wire logic bursting, // burst
  input wire logic standby, // idle
  input wire logic [39:0] securityCode, // code
  input wire logic codeStore // store
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (!rstn);
  logic [7:0] gap;
  logic [2:0] age;
  always_ff @(posedge sysClk or negedge rstn)
    if (!rstn) begin
      gap <= 8'h00;
      age <= 3'h7;
    end else begin
      gap <= $changed(serialData) ? 8'h00 : gap + (gap != 8'hFF);
      age <= (functionInputs != 4'hF) ? 3'h0 : age + (age != 3'h7);
    end
  sequence sAllUp;
    (functionInputs == 4'hF) [*5];
  endsequence
  sequence sBurstEnd;
    bursting ##1 !bursting;
  endsequence
  chk_bit_spacing: assert property ($changed(serialData) && bursting |->
    (gap >= BIT_DIV - 1) or (1'b1 ##[1:2] !bursting)) else $error("short bit");
  chk_idle_quiet: assert property (!bursting && !$past(bursting) |->
    !serialData) else $error("pin high outside burst");
  chk_release_stop: assert property (sAllUp |-> !bursting)
    else $error("burst outlives release");
  chk_end_store: assert property (sBurstEnd |-> ##[0:2] codeStore)
    else $error("no store after burst");
  chk_store_cause: assert property ($changed(securityCode) |->
    ##[0:1] codeStore) else $error("code changed without store");
  chk_standby_idle: assert property (standby |-> !bursting)
    else $error("standby during burst");
  chk_pin_drive: assert property (bursting |-> !serialDataEnN)
    else $error("pin not driven in burst");
  chk_press_cause: assert property ($rose(bursting) |-> age < 3'h6)
    else $error("burst without press");
  chk_mode_gate: assert property (!modeSelectPin [*8] |-> !bursting)
    else $error("burst in decoder mode");
endmodule
bind hce_frame_encoder hce_enc_chk #(.BIT_DIV(BIT_DIV)) uChk (
  .sysClk(sysClk), .rstn(rstn), .modeSelectPin(modeSelectPin),
  .functionInputs(functionInputs), .learnedFlag(learnedFlag),
  .serialData(serialData), .serialDataEnN(serialDataEnN),
  .bursting(bursting), .standby(standby),
  .securityCode(securityCode), .codeStore(codeStore));
`default_nettype wire

// ===== verif/hce_rx_model.sv
// Receiving decoder model for the serial frame
`timescale 1ns/1ps
`default_nettype none
module hce_rx_model #(parameter DIV = 2) (
  input wire logic sysClk, // clock
  input wire logic rstn, // reset
  input wire logic serialData, // pin
  output logic frameDone, // frame end
  output logic frameOk, // format good
  output logic [39:0] rxCode, // code
  output logic [3:0] rxF1, // packet 1
  output logic [3:0] rxF2, // packet 2
  output logic [3:0] funcOut // outputs, low
);
  logic [192:0] b;
  logic [8:0] pos;
  logic [15:0] ph;
  logic act, bad, ok;
  logic [39:0] code;
  logic [3:0] f1, f2;
  always @* begin
    ok = b[192];
    for (int k = 0; k < 48; k++) ok &= (b[k] == !k[0]);
    for (int k = 0; k < 48; k++) begin
      ok &= b[48 + 3 * k] & !b[50 + 3 * k];
      if (k < 40) code[k] = b[49 + 3 * k];
      else if (k < 44) f1[k - 40] = b[49 + 3 * k];
      else f2[k - 44] = b[49 + 3 * k];
    end
  end
  always @(posedge sysClk or negedge rstn)
    if (!rstn) begin
      act <= 1'b0;
      frameDone <= 1'b0;
      funcOut <= 4'hF;
    end else begin
      frameDone <= 1'b0;
      ph <= (ph == DIV - 1) ? 16'h0 : ph + 16'h1;
      if (!act && serialData) begin
        act <= 1'b1;
        ph <= 16'h1;
        pos <= 9'h1;
        b[0] <= 1'b1;
        bad <= 1'b0;
      end else if (act && ph == 16'h0) begin
        if (pos < 9'd193) b[pos] <= serialData;
        else bad <= bad | serialData;
        pos <= pos + 9'h1;
        if (pos == 9'd342) begin
          act <= 1'b0;
          frameDone <= 1'b1;
          frameOk <= ok & !bad & !serialData;
          rxCode <= code;
          rxF1 <= f1;
          rxF2 <= f2;
          if (ok && f1 == f2) funcOut <= f1;
        end
      end
    end
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the frame encoder
`include "hce_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 2;
  localparam int FRM = 343 * DIV;
  localparam int MAXF = 4;
  logic sysClk, rstn, modeSelectPin, learnedFlag;
  logic [3:0] functionInputs, pat;
  logic [39:0] code0;
  wire serialData, serialDataEnN, bursting, standby, codeStore;
  wire frameDone, frameOk;
  wire [39:0] securityCode, rxCode;
  wire [3:0] rxF1, rxF2, funcOut;
  int err_count, num_checks, seed, cyc, last, stores, frames;
  hce_frame_encoder #(.BIT_DIV(DIV), .MAX_FRAMES(MAXF)) dut (
    .sysClk(sysClk), .rstn(rstn),
    .modeSelectPin(modeSelectPin), .functionInputs(functionInputs),
    .learnedFlag(learnedFlag), .serialData(serialData),
    .serialDataEnN(serialDataEnN), .bursting(bursting), .standby(standby),
    .securityCode(securityCode), .codeStore(codeStore));
  hce_rx_model #(.DIV(DIV)) rx (.sysClk(sysClk), .rstn(rstn),
    .serialData(serialData), .frameDone(frameDone), .frameOk(frameOk),
    .rxCode(rxCode), .rxF1(rxF1), .rxF2(rxF2), .funcOut(funcOut));
  initial begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  always @(posedge sysClk) begin
    cyc <= cyc + 1;
    if (codeStore === 1'b1) stores <= stores + 1;
    if (frameDone === 1'b1) frames <= frames + 1;
  end
  task automatic check(input string what, input logic [63:0] e, g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic doReset(input logic mode, input logic lrn);
    @(posedge sysClk);
    rstn <= 1'b0;
    modeSelectPin <= mode;
    learnedFlag <= lrn;
    functionInputs <= 4'hF;
    repeat (3) @(posedge sysClk);
    rstn <= 1'b1;
    repeat (12) @(negedge sysClk);
  endtask
  task automatic press(input logic [3:0] p);
    @(posedge sysClk);
    functionInputs <= p;
  endtask
  function automatic logic [3:0] decOut(input logic [3:0] prev, a, c);
    return (a == c) ? a : prev;
  endfunction
  task automatic checkFrame(input logic [3:0] a, c);
    int n;
    logic [3:0] prev;
    n = 0;
    prev = funcOut;
    do @(negedge sysClk); while (frameDone !== 1'b1 && ++n < FRM + 99);
    check("frame seen", 1, frameDone);
    check("frame format", 1, frameOk);
    check("security code", code0, rxCode);
    check("packet one", a, rxF1);
    check("packet two", c, rxF2);
    check("decoder outputs", decOut(prev, a, c), funcOut);
  endtask
  task automatic letGo;
    int s;
    s = stores;
    press(4'hF);
    repeat (8) @(negedge sysClk);
    check("stopped", 0, {bursting, serialData});
    check("store count", s + 1, stores);
    check("code advanced", 1, securityCode !== code0);
    check("standby", 1, standby);
    repeat (FRM) @(posedge sysClk);
  endtask
  task automatic runBurst(input logic [3:0] p);
    code0 = securityCode;
    press(p);
    checkFrame(p, p);
    last = cyc;
    checkFrame(p, p);
    check("frame length", FRM, cyc - last);
    repeat (($random(seed) & 255) + 4) @(posedge sysClk);
    letGo;
    $display("burst %h done", p);
  endtask
  initial begin
    repeat (90000) @(posedge sysClk);
    err_count++;
    report_and_stop;
  end
  initial begin
    seed = 32'h4345;
    rstn = 1'b0;
    modeSelectPin = 1'b1;
    learnedFlag = 1'b1;
    functionInputs = 4'hF;
    doReset(1'b1, 1'b1);
    check("boot store", 1, stores);
    check("fresh code", 1, securityCode !== `HCE_SEED);
    check("pin enable", 0, serialDataEnN);
    check("standby", 1, standby);
    for (int i = 0; i < 4; i++) runBurst(4'hF & ~(4'h1 << i));
    repeat (3) begin
      pat = 4'($random(seed));
      if (pat == 4'hF) pat = 4'h6;
      runBurst(pat);
    end
    code0 = securityCode;
    press(4'hE);
    checkFrame(4'hE, 4'hE);
    repeat (80 * DIV) @(posedge sysClk);
    press(4'hC);
    checkFrame(4'hE, 4'hC);
    checkFrame(4'hC, 4'hC);
    letGo;
    $display("debounce done");
    code0 = securityCode;
    last = frames;
    press(4'h7);
    repeat (6 * FRM) @(negedge sysClk);
    check("frames sent", MAXF, frames - last);
    check("limit stop", 0, {bursting, serialData});
    check("code advanced", 1, securityCode !== code0);
    last = stores;
    press(4'h5);
    repeat (FRM) @(negedge sysClk);
    check("held press", 0, {bursting, serialData, standby});
    press(4'hF);
    repeat (8) @(negedge sysClk);
    check("standby", 1, standby);
    check("single store", last, stores);
    $display("limit done");
    doReset(1'b0, 1'b0);
    check("seed kept", `HCE_SEED, securityCode);
    press(4'hA);
    repeat (FRM) @(negedge sysClk);
    check("decoder mode idle", 0, {bursting, serialData});
    check("decoder pin off", 1, serialDataEnN);
    press(4'hF);
    $display("mode test done");
    report_and_stop;
  end
endmodule
`default_nettype wire
